// ### hw/bsc_pkg.sv
// shared constants of the tester status and counter block
package bsc_pkg;
	// register indices, byte address is four times the index
	localparam logic [9:0] IDX_LIVE_STATUS = 10'h06c;
	localparam logic [9:0] IDX_STICKY_STATUS = 10'h06e;
	localparam logic [9:0] IDX_IRQ_ENABLES = 10'h070;
	localparam logic [9:0] IDX_ERR_LOW = 10'h074;
	localparam logic [9:0] IDX_ERR_HIGH = 10'h076;
	localparam logic [9:0] IDX_BITS_LOW = 10'h078;
	localparam logic [9:0] IDX_BITS_HIGH = 10'h07a;
	localparam logic [9:0] IDX_CONTROL = 10'h080;
	// event bit positions shared by sticky and enable words, the live word carries all but bit error
	localparam int BIT_UPDATE_DONE = 3;
	localparam int BIT_BIT_ERROR = 2;
	localparam int BIT_ERRORS_NONZERO = 1;
	localparam int BIT_SYNC_LOSS = 0;
	localparam int NUM_EVENTS = 4;
	// control word fields
	localparam int BIT_LOCAL_UPDATE_REQUEST = 0;
	localparam int BIT_UPDATE_SOURCE_SELECT = 1;
	localparam int BIT_PORT_STATUS_IRQ_EN = 2;
	localparam int NUM_CONTROL = 3;
	// counter widths
	localparam int ERR_COUNT_W = 24;
	localparam int BIT_COUNT_W = 32;
	// reset values
	localparam logic [3:0] RST_IRQ_ENABLES = 4'h0;
	localparam logic [3:0] RST_STICKY = 4'h0;
	localparam logic [2:0] RST_CONTROL = 3'h0;
	localparam logic [15:0] RST_COUNT_WORD = 16'h0000;
endpackage : bsc_pkg

// ### hw/bsc_sat_counter.sv
// saturating up counter with synchronous restart
`timescale 1ns/1ps
module bsc_sat_counter #(
	parameter int W = 24
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_restart,
	input wire logic i_inc,
	output logic [W-1:0] o_count
);
	// a one bit counter cannot tell saturation from a single count
	if (W < 2) begin : g_bad_width
		$error("bsc_sat_counter width must be at least 2");
	end

	// restart keeps the increment of the same cycle so no event is lost
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_count <= '0;
		end
		else if (i_restart)
		begin
			o_count <= {{(W-1){1'b0}}, i_inc};
		end
		else if (i_inc && (o_count != {W{1'b1}}))
		begin
			o_count <= o_count + 1'b1;
		end
	end
endmodule : bsc_sat_counter

// ### hw/bsc_sticky_flags.sv
// bank of sticky flags, set wins over clear
`timescale 1ns/1ps
module bsc_sticky_flags #(
	parameter int W = 4
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_clr,
	output logic [W-1:0] o_flags
);
	if (W < 1) begin : g_bad_width
		$error("bsc_sticky_flags width must be at least 1");
	end

	// an event in the clearing cycle survives the clear
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_flags <= '0;
		end
		else
		begin
			o_flags <= (o_flags & ~i_clr) | i_set;
		end
	end
endmodule : bsc_sticky_flags

// ### hw/bsc_status_counters.sv
// tester receive status, sticky events, interrupt request and counters over apb
`timescale 1ns/1ps
module bsc_status_counters (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_rx_bit_valid,
	input wire logic i_rx_bit_error,
	input wire logic i_rx_out_of_sync,
	input wire logic i_port_update,
	output logic o_irq
);
	localparam int EW = bsc_pkg::ERR_COUNT_W;
	localparam int BW = bsc_pkg::BIT_COUNT_W;
	localparam int NE = bsc_pkg::NUM_EVENTS;

	// word index decode, used by read and write paths
	function automatic logic idx_hit(input logic [11:0] addr, input logic [9:0] idx);
		idx_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
	endfunction : idx_hit

	// byte lane mask for the low half word, the upper lanes carry no bits
	function automatic logic [15:0] lane_data(input logic [31:0] data, input logic [3:0] strb);
		lane_data = data[15:0] & {{8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_data

	logic [NE-1:0] irq_enables_r;
	logic [bsc_pkg::NUM_CONTROL-1:0] control_r;
	logic [NE-1:0] sticky_flags;
	logic [NE-1:0] sticky_set;
	logic [NE-1:0] sticky_clr;
	logic [EW-1:0] bit_error_count;
	logic [BW-1:0] received_bit_count;
	logic [EW-1:0] err_snapshot_r;
	logic [BW-1:0] bits_snapshot_r;
	logic update_req;
	logic update_req_d_r;
	logic counter_update_strobe;
	logic update_pending_r;
	logic update_done_status_r;
	logic update_done_status_nxt;
	logic errors_nonzero_status;
	logic errors_nonzero_d_r;
	logic sync_loss_d_r;
	logic count_enable;
	logic setup_phase;
	logic write_access;
	logic [15:0] wdata_lanes;
	logic [15:0] read_word;
	logic read_hit;
	logic irq_nxt;

	// apb phases, writes land only in the access cycle with pready high
	assign setup_phase = i_psel && !i_penable;
	assign write_access = i_psel && i_penable && o_pready && i_pwrite;
	assign wdata_lanes = lane_data(i_pwdata, i_pstrb);

	// update request source: local control bit or the port strobe input
	assign update_req = control_r[bsc_pkg::BIT_UPDATE_SOURCE_SELECT] ? i_port_update
		: control_r[bsc_pkg::BIT_LOCAL_UPDATE_REQUEST];
	assign counter_update_strobe = update_req && !update_req_d_r;

	// counting stops entirely while the checker has lost the pattern
	assign count_enable = i_rx_bit_valid && !i_rx_out_of_sync;

	// live nonzero status reads the running count, which restarts on update
	assign errors_nonzero_status = |bit_error_count;

	// live update status: set one cycle after the copy, dropped with the request
	always_comb
	begin
		update_done_status_nxt = update_done_status_r;
		if (!update_req)
		begin
			update_done_status_nxt = 1'b0;
		end
		else if (update_pending_r)
		begin
			update_done_status_nxt = 1'b1;
		end
	end

	// update sequencing state
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			update_req_d_r <= 1'b0;
			update_pending_r <= 1'b0;
			update_done_status_r <= 1'b0;
		end
		else
		begin
			update_req_d_r <= update_req;
			update_pending_r <= counter_update_strobe;
			update_done_status_r <= update_done_status_nxt;
		end
	end

	// delayed copies for edge detection of live status
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			errors_nonzero_d_r <= 1'b0;
			sync_loss_d_r <= 1'b0;
		end
		else
		begin
			errors_nonzero_d_r <= errors_nonzero_status;
			sync_loss_d_r <= i_rx_out_of_sync;
		end
	end

	// event detection feeding the sticky bank
	always_comb
	begin
		sticky_set = '0;
		sticky_set[bsc_pkg::BIT_UPDATE_DONE] = update_done_status_nxt && !update_done_status_r;
		sticky_set[bsc_pkg::BIT_BIT_ERROR] = i_rx_bit_valid && i_rx_bit_error;
		sticky_set[bsc_pkg::BIT_ERRORS_NONZERO] = errors_nonzero_status && !errors_nonzero_d_r;
		sticky_set[bsc_pkg::BIT_SYNC_LOSS] = i_rx_out_of_sync ^ sync_loss_d_r;
	end

	// write one to clear, zero bits are left alone
	assign sticky_clr = (write_access && idx_hit(i_paddr, bsc_pkg::IDX_STICKY_STATUS))
		? wdata_lanes[NE-1:0] : '0;

	bsc_sticky_flags #(
		.W(NE)
	) u_flags (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set(sticky_set),
		.i_clr(sticky_clr),
		.o_flags(sticky_flags)
	);

	// running counters restart on the update strobe
	bsc_sat_counter #(
		.W(EW)
	) u_err_count (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_restart(counter_update_strobe),
		.i_inc(count_enable && i_rx_bit_error),
		.o_count(bit_error_count)
	);

	bsc_sat_counter #(
		.W(BW)
	) u_bit_count (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_restart(counter_update_strobe),
		.i_inc(count_enable),
		.o_count(received_bit_count)
	);

	// software view of the counts moves only on the strobe
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			err_snapshot_r <= '0;
			bits_snapshot_r <= '0;
		end
		else if (counter_update_strobe)
		begin
			err_snapshot_r <= bit_error_count;
			bits_snapshot_r <= received_bit_count;
		end
	end

	// software written enables and control bits
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			irq_enables_r <= bsc_pkg::RST_IRQ_ENABLES;
			control_r <= bsc_pkg::RST_CONTROL;
		end
		else if (write_access)
		begin
			if (idx_hit(i_paddr, bsc_pkg::IDX_IRQ_ENABLES))
			begin
				irq_enables_r <= wdata_lanes[NE-1:0];
			end
			if (idx_hit(i_paddr, bsc_pkg::IDX_CONTROL))
			begin
				control_r <= wdata_lanes[bsc_pkg::NUM_CONTROL-1:0];
			end
		end
	end

	// read mux, unmapped indices answer with an error and zero data
	always_comb
	begin
		read_word = bsc_pkg::RST_COUNT_WORD;
		read_hit = 1'b1;
		if (idx_hit(i_paddr, bsc_pkg::IDX_LIVE_STATUS))
		begin
			read_word[bsc_pkg::BIT_UPDATE_DONE] = update_done_status_r;
			read_word[bsc_pkg::BIT_ERRORS_NONZERO] = errors_nonzero_status;
			read_word[bsc_pkg::BIT_SYNC_LOSS] = i_rx_out_of_sync;
		end
		else if (idx_hit(i_paddr, bsc_pkg::IDX_STICKY_STATUS))
		begin
			read_word[NE-1:0] = sticky_flags;
		end
		else if (idx_hit(i_paddr, bsc_pkg::IDX_IRQ_ENABLES))
		begin
			read_word[NE-1:0] = irq_enables_r;
		end
		else if (idx_hit(i_paddr, bsc_pkg::IDX_ERR_LOW))
		begin
			read_word = err_snapshot_r[15:0];
		end
		else if (idx_hit(i_paddr, bsc_pkg::IDX_ERR_HIGH))
		begin
			read_word[7:0] = err_snapshot_r[EW-1:16];
		end
		else if (idx_hit(i_paddr, bsc_pkg::IDX_BITS_LOW))
		begin
			read_word = bits_snapshot_r[15:0];
		end
		else if (idx_hit(i_paddr, bsc_pkg::IDX_BITS_HIGH))
		begin
			read_word = bits_snapshot_r[BW-1:16];
		end
		else if (idx_hit(i_paddr, bsc_pkg::IDX_CONTROL))
		begin
			read_word[bsc_pkg::NUM_CONTROL-1:0] = control_r;
		end
		else
		begin
			read_hit = 1'b0;
		end
	end

	// answer is prepared in setup so pready and data come straight from flops
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= '0;
		end
		else
		begin
			o_pready <= setup_phase;
			o_pslverr <= setup_phase && !read_hit;
			o_prdata <= (setup_phase && !i_pwrite) ? {16'h0000, read_word} : 32'h0000_0000;
		end
	end

	// interrupt request, update-done skips the port enable
	always_comb
	begin
		irq_nxt = sticky_flags[bsc_pkg::BIT_UPDATE_DONE] && irq_enables_r[bsc_pkg::BIT_UPDATE_DONE];
		if (control_r[bsc_pkg::BIT_PORT_STATUS_IRQ_EN])
		begin
			irq_nxt = irq_nxt
				|| (sticky_flags[bsc_pkg::BIT_BIT_ERROR] && irq_enables_r[bsc_pkg::BIT_BIT_ERROR])
				|| (sticky_flags[bsc_pkg::BIT_ERRORS_NONZERO] && irq_enables_r[bsc_pkg::BIT_ERRORS_NONZERO])
				|| (sticky_flags[bsc_pkg::BIT_SYNC_LOSS] && irq_enables_r[bsc_pkg::BIT_SYNC_LOSS]);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_irq <= 1'b0;
		end
		else
		begin
			o_irq <= irq_nxt;
		end
	end

	// checks on the event, interrupt and counter paths
	property p_update_latch;
		@(posedge i_clk) disable iff (i_rst)
		$rose(update_done_status_r) |-> sticky_flags[bsc_pkg::BIT_UPDATE_DONE];
	endproperty
	a_update_latch: assert property (p_update_latch) else $error("update done not latched");

	property p_bit_error_latch;
		@(posedge i_clk) disable iff (i_rst)
		(i_rx_bit_valid && i_rx_bit_error) |=> sticky_flags[bsc_pkg::BIT_BIT_ERROR];
	endproperty
	a_bit_error_latch: assert property (p_bit_error_latch) else $error("bit error not latched");

	property p_nonzero_latch;
		@(posedge i_clk) disable iff (i_rst)
		(errors_nonzero_status && !errors_nonzero_d_r) |=> sticky_flags[bsc_pkg::BIT_ERRORS_NONZERO];
	endproperty
	a_nonzero_latch: assert property (p_nonzero_latch) else $error("nonzero not latched");

	property p_sync_latch;
		@(posedge i_clk) disable iff (i_rst)
		(i_rx_out_of_sync != sync_loss_d_r) |=> sticky_flags[bsc_pkg::BIT_SYNC_LOSS];
	endproperty
	a_sync_latch: assert property (p_sync_latch) else $error("sync change not latched");

	property p_irq_update;
		@(posedge i_clk) disable iff (i_rst)
		(sticky_flags[bsc_pkg::BIT_UPDATE_DONE] && irq_enables_r[bsc_pkg::BIT_UPDATE_DONE]) |=> o_irq;
	endproperty
	a_irq_update: assert property (p_irq_update) else $error("update irq missing");

	property p_irq_port_gate;
		@(posedge i_clk) disable iff (i_rst)
		(!control_r[bsc_pkg::BIT_PORT_STATUS_IRQ_EN]
			&& !(sticky_flags[bsc_pkg::BIT_UPDATE_DONE] && irq_enables_r[bsc_pkg::BIT_UPDATE_DONE])) |=> !o_irq;
	endproperty
	a_irq_port_gate: assert property (p_irq_port_gate) else $error("irq without port enable");

	property p_irq_port_on;
		@(posedge i_clk) disable iff (i_rst)
		(control_r[bsc_pkg::BIT_PORT_STATUS_IRQ_EN] && |(sticky_flags[2:0] & irq_enables_r[2:0])) |=> o_irq;
	endproperty
	a_irq_port_on: assert property (p_irq_port_on) else $error("port irq missing");

	property p_err_saturate;
		@(posedge i_clk) disable iff (i_rst)
		(bit_error_count == {EW{1'b1}} && !counter_update_strobe) |=> (bit_error_count == {EW{1'b1}});
	endproperty
	a_err_saturate: assert property (p_err_saturate) else $error("error count wrapped");

	property p_freeze;
		@(posedge i_clk) disable iff (i_rst)
		(i_rx_out_of_sync && !counter_update_strobe) |=> ($stable(bit_error_count) && $stable(received_bit_count));
	endproperty
	a_freeze: assert property (p_freeze) else $error("count moved out of sync");

	property p_bit_count_step;
		@(posedge i_clk) disable iff (i_rst)
		(count_enable && !counter_update_strobe && received_bit_count != {BW{1'b1}})
			|=> (received_bit_count == $past(received_bit_count) + 32'h0000_0001);
	endproperty
	a_bit_count_step: assert property (p_bit_count_step) else $error("bit count step wrong");

	property p_snapshot_hold;
		@(posedge i_clk) disable iff (i_rst)
		!counter_update_strobe |=> ($stable(err_snapshot_r) && $stable(bits_snapshot_r));
	endproperty
	a_snapshot_hold: assert property (p_snapshot_hold) else $error("snapshot moved without update");

	property p_snapshot_copy;
		@(posedge i_clk) disable iff (i_rst)
		counter_update_strobe |=> (err_snapshot_r == $past(bit_error_count)
			&& received_bit_count <= 32'h0000_0001);
	endproperty
	a_snapshot_copy: assert property (p_snapshot_copy) else $error("update copy or restart wrong");

	property p_status_drop;
		@(posedge i_clk) disable iff (i_rst)
		!update_req |=> !update_done_status_r ##1 (!update_req || !update_done_status_r || update_pending_r);
	endproperty
	a_status_drop: assert property (p_status_drop) else $error("update status not dropped");

	property p_w1c;
		@(posedge i_clk) disable iff (i_rst)
		(sticky_clr[bsc_pkg::BIT_BIT_ERROR] && !sticky_set[bsc_pkg::BIT_BIT_ERROR])
			|=> !sticky_flags[bsc_pkg::BIT_BIT_ERROR];
	endproperty
	a_w1c: assert property (p_w1c) else $error("sticky bit not cleared");

	c_update: cover property (@(posedge i_clk) disable iff (i_rst) counter_update_strobe ##2 update_done_status_r);
	c_irq: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_irq));
	c_sync_change: cover property (@(posedge i_clk) disable iff (i_rst) $fell(i_rx_out_of_sync) ##[1:20] count_enable);
endmodule : bsc_status_counters

// ### test/tb_top.sv
// self-checking bench for the tester status and counter block
`timescale 1ns/1ps
module tb_top;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hf;
	logic bit_valid = 1'b0;
	logic bit_error = 1'b0;
	logic out_of_sync = 1'b0;
	logic port_update = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	int fail_count = 0;
	int compares = 0;
	logic [31:0] seed = 32'h402c01ee;
	// reference model state, counts kept in plain integers
	longint err_cnt = 0;
	longint bit_cnt = 0;
	longint err_snap = 0;
	longint bit_snap = 0;
	logic [3:0] stk = 4'h0;
	logic [3:0] ena = 4'h0;
	logic [2:0] ctl = 3'h0;
	logic upd_live = 1'b0;
	logic [31:0] rd;
	logic err;

	bsc_status_counters uut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_psel(psel),
		.i_penable(penable),
		.i_pwrite(pwrite),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.i_pstrb(pstrb),
		.o_prdata(prdata),
		.o_pready(pready),
		.o_pslverr(pslverr),
		.i_rx_bit_valid(bit_valid),
		.i_rx_bit_error(bit_error),
		.i_rx_out_of_sync(out_of_sync),
		.i_port_update(port_update),
		.o_irq(irq)
	);

	// free-running line clock, 50 ns period
	initial
	begin
		forever #25 i_clk = ~i_clk;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xorshift

	task automatic final_report;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		int k;
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge i_clk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20)
		begin
			fail_count++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr_reg(input logic [9:0] idx, input logic [15:0] d);
		apb(1'b1, {idx, 2'b00}, {16'h0000, d});
	endtask : wr_reg

	task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, {idx, 2'b00}, 32'h00000000);
		check(rd, exp);
		check({31'h0, err}, 32'h00000000);
	endtask : rd_chk

	task automatic chk_live;
		rd_chk(bsc_pkg::IDX_LIVE_STATUS, {28'h0, upd_live, 1'b0, err_cnt != 0, out_of_sync});
		rd_chk(bsc_pkg::IDX_STICKY_STATUS, {28'h0, stk});
	endtask : chk_live

	// both halves of each count come from the same snapshot
	task automatic chk_counts;
		rd_chk(bsc_pkg::IDX_ERR_LOW, {16'h0, err_snap[15:0]});
		rd_chk(bsc_pkg::IDX_ERR_HIGH, {24'h0, err_snap[23:16]});
		rd_chk(bsc_pkg::IDX_BITS_LOW, {16'h0, bit_snap[15:0]});
		rd_chk(bsc_pkg::IDX_BITS_HIGH, {16'h0, bit_snap[31:16]});
	endtask : chk_counts

	// random received bits; the model counts what the design samples
	task automatic stream(input int n, input logic lost);
		int i;
		logic v;
		logic e;
		if (lost !== out_of_sync)
			stk[0] = 1'b1;
		for (i = 0; i < n; i++)
		begin
			@(posedge i_clk);
			seed = xorshift(seed);
			v = seed[0] | seed[1];
			e = v & (seed[7:4] == 4'h0);
			bit_valid <= v;
			bit_error <= e;
			out_of_sync <= lost;
			if (e)
				stk[2] = 1'b1;
			if (v && !lost)
			begin
				if (bit_cnt < 64'hffffffff)
					bit_cnt++;
				if (e && err_cnt < 64'hffffff)
				begin
					if (err_cnt == 0)
						stk[1] = 1'b1;
					err_cnt++;
				end
			end
		end
		@(posedge i_clk);
		bit_valid <= 1'b0;
		bit_error <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask : stream

	// stream is idle here, so the restart keeps no increment
	task automatic do_update(input logic via_pin);
		if (via_pin)
		begin
			@(posedge i_clk);
			port_update <= 1'b1;
		end
		else
		begin
			ctl[0] = 1'b1;
			wr_reg(bsc_pkg::IDX_CONTROL, {13'h0, ctl});
		end
		repeat (4) @(posedge i_clk);
		err_snap = err_cnt;
		bit_snap = bit_cnt;
		err_cnt = 0;
		bit_cnt = 0;
		stk[3] = 1'b1;
		upd_live = 1'b1;
		chk_live();
		chk_counts();
		if (via_pin)
			port_update <= 1'b0;
		else
		begin
			ctl[0] = 1'b0;
			wr_reg(bsc_pkg::IDX_CONTROL, {13'h0, ctl});
		end
		repeat (3) @(posedge i_clk);
		upd_live = 1'b0;
		chk_live();
	endtask : do_update

	task automatic chk_irq;
		logic exp;
		repeat (3) @(posedge i_clk);
		exp = (stk[3] & ena[3]) | (ctl[2] & |(stk[2:0] & ena[2:0]));
		check({31'h0, irq}, {31'h0, exp});
	endtask : chk_irq

	// main sequence
	initial
	begin
		int pe;
		int b;
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		chk_live();
		rd_chk(bsc_pkg::IDX_IRQ_ENABLES, 32'h0);
		rd_chk(bsc_pkg::IDX_CONTROL, 32'h0);
		chk_counts();
		apb(1'b0, {10'h072, 2'b00}, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		apb(1'b1, {bsc_pkg::IDX_IRQ_ENABLES, 2'b10}, 32'h0000000f);
		check({31'h0, err}, 32'h1);
		rd_chk(bsc_pkg::IDX_IRQ_ENABLES, 32'h0);
		wr_reg(bsc_pkg::IDX_ERR_LOW, 16'hffff);
		chk_counts();
		$display("test reset_map done");
		stream(300, 1'b0);
		chk_live();
		chk_counts();
		do_update(1'b0);
		$display("test local_update done");
		stream(200, 1'b1);
		chk_live();
		stream(60, 1'b0);
		chk_live();
		ctl[1] = 1'b1;
		wr_reg(bsc_pkg::IDX_CONTROL, {13'h0, ctl});
		do_update(1'b1);
		$display("test sync_loss_freeze done");
		wr_reg(bsc_pkg::IDX_STICKY_STATUS, 16'h0000);
		chk_live();
		for (pe = 0; pe < 2; pe++)
		begin
			ctl[2] = pe[0];
			wr_reg(bsc_pkg::IDX_CONTROL, {13'h0, ctl});
			for (b = 0; b < 4; b++)
			begin
				ena = 4'h1 << b;
				wr_reg(bsc_pkg::IDX_IRQ_ENABLES, {12'h0, ena});
				chk_irq();
			end
		end
		seed = xorshift(seed);
		ena = seed[3:0];
		wr_reg(bsc_pkg::IDX_IRQ_ENABLES, seed[15:0]);
		rd_chk(bsc_pkg::IDX_IRQ_ENABLES, {28'h0, ena});
		wr_reg(bsc_pkg::IDX_STICKY_STATUS, 16'h0005);
		stk = stk & 4'ha;
		chk_live();
		chk_irq();
		wr_reg(bsc_pkg::IDX_STICKY_STATUS, 16'hffff);
		stk = 4'h0;
		chk_live();
		chk_irq();
		$display("test irq_and_clear done");
		final_report();
	end
endmodule : tb_top
